// ==== verilog/tap_defs.vh ====
// test access port constants: states, instruction codes, register sizes
// assumes the including module runs on one system clock and samples the test pins itself
//
// Notes on behaviour
// - all port activity follows test clock; state moves on mode-select at rising edge
// - only four port pins; no separate asynchronous test reset input exists
// - enable fuse clear: pins are plain general-purpose pins, controller held reset
// - fuse set and disable bit clear: pins pulled high, scan and programming enabled
// - controller is a sixteen-state machine steering scan, programming and debug logic
// - after power-on reset the controller sits in test-logic-reset
// - every scan register shifts least significant bit in and out first
// - four-bit instruction; low three bits with select low, top bit on exit edge
// - during instruction shift the captured value 0x01 goes out on data out
// - select 1,1,0 returns to idle; instruction latched during instruction update
// - current instruction picks the data register between data in and data out
// - data enters on rising clock; top bit enters as select rises to exit
// - during data shift the values captured in data capture go out
// - registers with latched outputs change only in data update
// - exit, pause and second-exit states do nothing but navigate
// - idle need not be visited; some instructions work during idle
// - five clocks with select high reach test-logic-reset from any state
// - data registers: identity, bypass, boundary, programming, internal and break chains
`ifndef TAP_DEFS_VH
`define TAP_DEFS_VH
// controller states
`define ST_RESET      4'h0
`define ST_IDLE       4'h1
`define ST_SEL_DR     4'h2
`define ST_CAP_DR     4'h3
`define ST_SHIFT_DR   4'h4
`define ST_EXIT1_DR   4'h5
`define ST_PAUSE_DR   4'h6
`define ST_EXIT2_DR   4'h7
`define ST_UPD_DR     4'h8
`define ST_SEL_IR     4'h9
`define ST_CAP_IR     4'hA
`define ST_SHIFT_IR   4'hB
`define ST_EXIT1_IR   4'hC
`define ST_PAUSE_IR   4'hD
`define ST_EXIT2_IR   4'hE
`define ST_UPD_IR     4'hF
// instruction codes
`define IR_WIDTH      4
`define IR_CAPTURE    4'h1
`define IR_EXTEST     4'h0
`define IR_IDCODE     4'h1
`define IR_SAMPLE     4'h2
`define IR_PROG       4'h4
`define IR_RESET_INS  4'hC
`define IR_BYPASS     4'hF
`define IR_DBG_LO     4'h8
`define IR_DBG_HI     4'hB
`define ID_WIDTH      32
`endif

// ==== verilog/tap_controller.v ====
// test access port controller with instruction register and data register mux
// assumes test pins arrive asynchronous to sys_clk, test clock well below sys_clk/4
`timescale 1ns/1ps
`include "tap_defs.vh"

module tap_controller #(
   parameter                 BSR_LEN  = 16,
   parameter                 PROG_LEN = 16,
   parameter                 CHN_LEN  = 16,
   parameter [`ID_WIDTH-1:0] ID_VALUE = 32'h00000001 // arbitrary identity value
) (
   // system
   input  wire                sys_clk,
   input  wire                rst,
   // enable controls
   input  wire                test_port_enable_fuse,
   input  wire                test_port_disable_bit,
   // test pins
   input  wire                tck,
   input  wire                tms,
   input  wire                tdi,
   output reg                 tdo_o,
   output reg                 tdo_oe,
   output wire                pin_pullup_en,
   output wire                port_enabled,
   // parallel side of data registers
   input  wire [BSR_LEN-1:0]  bsr_capture,
   output reg  [BSR_LEN-1:0]  bsr_update_r,
   input  wire [PROG_LEN-1:0] prog_capture,
   output reg  [PROG_LEN-1:0] prog_update_r,
   input  wire [CHN_LEN-1:0]  dbg_capture,
   output reg  [CHN_LEN-1:0]  dbg_update_r,
   // controller status
   output reg  [3:0]          ir_r,
   output reg  [3:0]          state_r,
   output wire                in_idle,
   output wire                sys_reset_req
);

   localparam SR_W = (BSR_LEN > `ID_WIDTH) ? BSR_LEN : `ID_WIDTH;

   // two-stage synchronisers for the test pins
   reg  [2:0] s1_r;
   reg  [2:0] s2_r;
   reg        tck_d_r;
   reg [3:0]  state_nxt;
   reg [3:0]  ir_sh_r;
   reg [SR_W-1:0] dr_sh_r;
   wire [1:0] dsel;

   wire tck_s = s2_r[2];
   wire tms_s = s2_r[1];
   wire tdi_s = s2_r[0];
   wire rise  = tck_s & ~tck_d_r;
   wire fall  = ~tck_s & tck_d_r;

   assign port_enabled  = test_port_enable_fuse & ~test_port_disable_bit;
   assign pin_pullup_en = port_enabled;
   assign in_idle       = (state_r == `ST_IDLE);
   assign sys_reset_req = (ir_r == `IR_RESET_INS);

   always @(posedge sys_clk) begin
      if (rst) begin
         s1_r    <= 3'h0;
         s2_r    <= 3'h0;
         tck_d_r <= 1'b0;
      end else begin
         s1_r    <= {tck, tms, tdi};
         s2_r    <= s1_r;
         tck_d_r <= tck_s;
      end
   end

   // data register select per instruction: 1 boundary, 2 programming, 3 debug chain, 0 identity or bypass; bypass is one bit
   function [1:0] dr_sel;
      input [3:0] ins;
      begin
         if (ins == `IR_EXTEST || ins == `IR_SAMPLE)
            dr_sel = 2'h1;
         else if (ins == `IR_PROG)
            dr_sel = 2'h2;
         else if (ins >= `IR_DBG_LO && ins <= `IR_DBG_HI)
            dr_sel = 2'h3;
         else
            dr_sel = 2'h0;
      end
   endfunction

   // register select decoded once from the current instruction
   assign dsel = dr_sel(ir_r);

   // next state; sixteen states, moves on select at each rising test clock
   always @* begin
      case (state_r)
         `ST_RESET:    state_nxt = tms_s ? `ST_RESET   : `ST_IDLE;
         `ST_IDLE:     state_nxt = tms_s ? `ST_SEL_DR  : `ST_IDLE;
         `ST_SEL_DR:   state_nxt = tms_s ? `ST_SEL_IR  : `ST_CAP_DR;
         `ST_CAP_DR:   state_nxt = tms_s ? `ST_EXIT1_DR : `ST_SHIFT_DR;
         `ST_SHIFT_DR: state_nxt = tms_s ? `ST_EXIT1_DR : `ST_SHIFT_DR;
         `ST_EXIT1_DR: state_nxt = tms_s ? `ST_UPD_DR  : `ST_PAUSE_DR;
         `ST_PAUSE_DR: state_nxt = tms_s ? `ST_EXIT2_DR : `ST_PAUSE_DR;
         `ST_EXIT2_DR: state_nxt = tms_s ? `ST_UPD_DR  : `ST_SHIFT_DR;
         `ST_UPD_DR:   state_nxt = tms_s ? `ST_SEL_DR  : `ST_IDLE;
         `ST_SEL_IR:   state_nxt = tms_s ? `ST_RESET   : `ST_CAP_IR;
         `ST_CAP_IR:   state_nxt = tms_s ? `ST_EXIT1_IR : `ST_SHIFT_IR;
         `ST_SHIFT_IR: state_nxt = tms_s ? `ST_EXIT1_IR : `ST_SHIFT_IR;
         `ST_EXIT1_IR: state_nxt = tms_s ? `ST_UPD_IR  : `ST_PAUSE_IR;
         `ST_PAUSE_IR: state_nxt = tms_s ? `ST_EXIT2_IR : `ST_PAUSE_IR;
         `ST_EXIT2_IR: state_nxt = tms_s ? `ST_UPD_IR  : `ST_SHIFT_IR;
         `ST_UPD_IR:   state_nxt = tms_s ? `ST_SEL_DR  : `ST_IDLE;
         default:      state_nxt = `ST_RESET;
      endcase
   end

   // state register; no test reset pin, so only rst, the fuse and the disable bit force reset
   always @(posedge sys_clk) begin
      if (rst || !port_enabled)
         state_r <= `ST_RESET;
      else if (rise)
         state_r <= state_nxt;
   end

   // instruction shift and latch; capture loads 0x01, lsb shifts first
   always @(posedge sys_clk) begin
      if (rst || !port_enabled) begin
         ir_sh_r <= `IR_CAPTURE;
         ir_r    <= `IR_IDCODE;
      end else if (rise) begin
         // identity instruction loads on the edge that enters reset, not one later
         if (state_nxt == `ST_RESET)
            ir_r <= `IR_IDCODE;
         case (state_r)
            `ST_CAP_IR:   ir_sh_r <= `IR_CAPTURE;
            `ST_SHIFT_IR: ir_sh_r <= {tdi_s, ir_sh_r[3:1]};
            `ST_UPD_IR:   ir_r    <= ir_sh_r;
            default:      ir_sh_r <= ir_sh_r;
         endcase
      end
   end

   // data path: capture, shift and update of the selected register
   always @(posedge sys_clk) begin
      if (rst || !port_enabled) begin
         dr_sh_r       <= {SR_W{1'b0}};
         bsr_update_r  <= {BSR_LEN{1'b0}};
         prog_update_r <= {PROG_LEN{1'b0}};
         dbg_update_r  <= {CHN_LEN{1'b0}};
      end else if (rise) begin
         case (state_r)
            `ST_CAP_DR: begin
               // clear first, then load the low part; avoids zero-width padding
               dr_sh_r <= {SR_W{1'b0}};
               case (dsel)
                  2'h1:    dr_sh_r[BSR_LEN-1:0]  <= bsr_capture;
                  2'h2:    dr_sh_r[PROG_LEN-1:0] <= prog_capture;
                  2'h3:    dr_sh_r[CHN_LEN-1:0]  <= dbg_capture;
                  default: begin
                     if (ir_r == `IR_IDCODE)
                        dr_sh_r[`ID_WIDTH-1:0] <= ID_VALUE;
                  end
               endcase
            end
            `ST_SHIFT_DR: begin
               case (dsel)
                  2'h1:    dr_sh_r[BSR_LEN-1:0]  <= {tdi_s, dr_sh_r[BSR_LEN-1:1]};
                  2'h2:    dr_sh_r[PROG_LEN-1:0] <= {tdi_s, dr_sh_r[PROG_LEN-1:1]};
                  2'h3:    dr_sh_r[CHN_LEN-1:0]  <= {tdi_s, dr_sh_r[CHN_LEN-1:1]};
                  default: begin
                     if (ir_r == `IR_IDCODE)
                        dr_sh_r[`ID_WIDTH-1:0] <= {tdi_s, dr_sh_r[`ID_WIDTH-1:1]};
                     else
                        dr_sh_r[0] <= tdi_s; // bypass
                  end
               endcase
            end
            `ST_UPD_DR: begin
               case (dsel)
                  2'h1:    bsr_update_r  <= dr_sh_r[BSR_LEN-1:0];
                  2'h2:    prog_update_r <= dr_sh_r[PROG_LEN-1:0];
                  2'h3:    dbg_update_r  <= dr_sh_r[CHN_LEN-1:0];
                  default: dbg_update_r  <= dbg_update_r;
               endcase
            end
            default: dr_sh_r <= dr_sh_r;
         endcase
      end
   end

   // serial out changes on falling test clock, enabled from a falling edge in a shift state to the next falling edge
   always @(posedge sys_clk) begin
      if (rst || !port_enabled) begin
         tdo_o  <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (fall) begin
         tdo_oe <= (state_r == `ST_SHIFT_IR) || (state_r == `ST_SHIFT_DR);
         tdo_o  <= (state_r == `ST_SHIFT_IR) ? ir_sh_r[0] : dr_sh_r[0];
      end
   end

endmodule // tap_controller

// ==== tb/tap_properties.sv ====
// checker for the test access port controller outputs
// assumes one system clock, synchronous active-high reset
`timescale 1ns/1ps
`include "tap_defs.vh"
module tap_properties #(parameter BSR_LEN = 16) (
   // system
   input wire               sys_clk,
   input wire               rst,
   // watched ports
   input wire               test_port_enable_fuse,
   input wire               test_port_disable_bit,
   input wire               tdo_oe,
   input wire               pin_pullup_en,
   input wire               port_enabled,
   input wire [BSR_LEN-1:0] bsr_update_r,
   input wire [3:0]         ir_r,
   input wire [3:0]         state_r,
   input wire               in_idle,
   input wire               sys_reset_req
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_pull; pin_pullup_en == (test_port_enable_fuse & ~test_port_disable_bit); endproperty
   a_pull: assert property (p_pull) else $error("pull-up enable mismatch");
   property p_off; !port_enabled |=> state_r == `ST_RESET; endproperty
   a_off: assert property (p_off) else $error("disabled port not held in reset");
   // drive window includes exit1 since tdo only moves on falling tck
   property p_oe; tdo_oe |-> state_r inside {`ST_SHIFT_DR, `ST_EXIT1_DR, `ST_SHIFT_IR, `ST_EXIT1_IR}; endproperty
   a_oe: assert property (p_oe) else $error("tdo driven outside shift");
   property p_ir; !$stable(ir_r) |-> ($past(state_r) inside {`ST_UPD_IR, `ST_RESET}) || (state_r inside {`ST_UPD_IR, `ST_RESET}); endproperty
   a_ir: assert property (p_ir) else $error("instruction changed outside update");
   property p_upd; !$stable(bsr_update_r) |-> ($past(state_r) inside {`ST_UPD_DR, `ST_RESET}) || (state_r inside {`ST_UPD_DR, `ST_RESET}); endproperty
   a_upd: assert property (p_upd) else $error("latched output changed outside update");
   property p_tlr; state_r == `ST_RESET [*2] |-> ir_r == `IR_IDCODE; endproperty
   a_tlr: assert property (p_tlr) else $error("reset state without identity instruction");
   // the state holds for at least nine system clocks after each move
   property p_step; !$stable(state_r) |=> $stable(state_r) [*8]; endproperty
   a_step: assert property (p_step) else $error("state moved twice in one tck period");
   property p_sys; sys_reset_req == (ir_r == `IR_RESET_INS); endproperty
   a_sys: assert property (p_sys) else $error("system reset request mismatch");
   property p_idle; in_idle == (state_r == `ST_IDLE); endproperty
   a_idle: assert property (p_idle) else $error("idle flag mismatch");
   c_shdr: cover property (state_r == `ST_SHIFT_DR);
   c_byp: cover property (ir_r == `IR_BYPASS);
   c_off: cover property (!port_enabled);
endmodule // tap_properties
bind tap_controller tap_properties #(.BSR_LEN(BSR_LEN)) u_props (.sys_clk, .rst, .test_port_enable_fuse,
   .test_port_disable_bit, .tdo_oe, .pin_pullup_en, .port_enabled, .bsr_update_r, .ir_r, .state_r, .in_idle,
   .sys_reset_req);

// ==== tb/tap_host.sv ====
// external test controller model driving tck, tms and tdi
// assumes a 160 ns tck that stands still low between frames
`timescale 1ns/1ps
module tap_host (
   // test pins
   output reg  tck,
   output reg  tms,
   output reg  tdi,
   input  wire tdo_o
);
   // no test reset pin exists, so none is driven
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // one tck period; tdo sampled just before the rising edge
   task step(input reg m, input reg d, output reg q);
      begin
         tms = m;
         tdi = d;
         #80 q = tdo_o;
         tck = 1'b1;
         #80 tck = 1'b0;
      end
   endtask
   // five high periods reach reset from anywhere
   task tlr;
      reg q;
      begin
         repeat (5) step(1'b1, ~tdi, q);
      end
   endtask
   // idle to shift, n bits lsb first, then update and back to idle
   task walk(input reg ir, input reg [63:0] v, input integer n, output reg [63:0] r);
      integer i;
      reg q;
      begin
         step(1'b1, ~tdi, q);
         if (ir) begin
            step(1'b1, ~tdi, q);
         end
         step(1'b0, ~tdi, q);
         step(1'b0, ~tdi, q);
         r = 64'h0;
         for (i = 0; i < n; i = i + 1) begin
            step(i == n - 1, v[i], q);
            r[i] = q;
         end
         step(1'b1, ~tdi, q);
         step(1'b0, ~tdi, q);
      end
   endtask
endmodule // tap_host

// ==== tb/test_jtag_tap_controller.sv ====
// testbench for the test access port controller
// assumes tap_host as the far side and the bound checker
`timescale 1ns/1ps
`include "tap_defs.vh"
module test_jtag_tap_controller;
   reg         sys_clk = 1'b0;
   reg         rst = 1'b1;
   reg         test_port_enable_fuse = 1'b1;
   reg         test_port_disable_bit = 1'b0;
   reg  [15:0] bsr_capture = 16'hA5C3;
   reg  [15:0] prog_capture = 16'h1E87;
   reg  [15:0] dbg_capture = 16'h6B09;
   wire        tck, tms, tdi, tdo_o, tdo_oe, pin_pullup_en, port_enabled, in_idle, sys_reset_req;
   wire [15:0] bsr_update_r, prog_update_r, dbg_update_r;
   wire [3:0]  ir_r, state_r;
   integer     bad_count = 0;
   integer     num_checks = 0;
   reg  [63:0] r;
   reg         q;
   always #2.5 sys_clk = ~sys_clk;
   tap_controller dut (.sys_clk, .rst, .test_port_enable_fuse, .test_port_disable_bit, .tck, .tms, .tdi, .tdo_o,
      .tdo_oe, .pin_pullup_en, .port_enabled, .bsr_capture, .bsr_update_r, .prog_capture, .prog_update_r,
      .dbg_capture, .dbg_update_r, .ir_r, .state_r, .in_idle, .sys_reset_req);
   tap_host host (.tck, .tms, .tdi, .tdo_o);
   task check(input [63:0] got, input [63:0] exp);
      begin
         num_checks = num_checks + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", num_checks, bad_count);
         if (bad_count == 0 && num_checks > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   // capture pattern, bypass and identity paths
   task test_ir;
      begin
         host.walk(1'b1, 64'hF, 4, r);
         check(r[3:0], 4'h1);
         check(ir_r, 4'hF);
         host.walk(1'b0, 64'h5, 3, r);
         check(r[2:0], 3'h2);
         host.walk(1'b1, 64'h1, 4, r);
         host.walk(1'b0, 64'h0, 32, r);
         check(r[31:0], 32'h00000001);
         $display("test_ir done");
      end
   endtask
   // chosen chain captures and updates; for 0x0 and 0x4 one other latched output must keep its value
   task test_chain(input [3:0] code);
      begin
         host.walk(1'b1, {60'h0, code}, 4, r);
         host.walk(1'b0, 64'h3C5A, 16, r);
         case (code)
            4'h0: check({prog_update_r, bsr_update_r, r[15:0]}, 48'h00003C5AA5C3);
            4'h4: check({dbg_update_r, prog_update_r, r[15:0]}, 48'h00003C5A1E87);
            default: check({dbg_update_r, r[15:0]}, 32'h3C5A6B09);
         endcase
         $display("test_chain %h done", code);
      end
   endtask
   // leave mid-shift with five high periods
   task test_reset;
      begin
         host.walk(1'b1, 64'hC, 4, r);
         check(sys_reset_req, 1'b1);
         host.step(1'b1, 1'b0, q);
         host.step(1'b0, 1'b1, q);
         host.step(1'b0, 1'b0, q);
         host.tlr;
         check({state_r, ir_r, sys_reset_req}, {`ST_RESET, `IR_IDCODE, 1'b0});
         host.step(1'b0, 1'b1, q);
         $display("test_reset done");
      end
   endtask
   // disable bit, then cleared fuse, then enabled again
   task test_port;
      begin
         @(negedge sys_clk) test_port_disable_bit = 1'b1;
         repeat (3) @(negedge sys_clk);
         check({pin_pullup_en, port_enabled, state_r}, {2'b00, `ST_RESET});
         test_port_disable_bit = 1'b0;
         test_port_enable_fuse = 1'b0;
         repeat (3) @(negedge sys_clk);
         check({pin_pullup_en, state_r}, {1'b0, `ST_RESET});
         test_port_enable_fuse = 1'b1;
         @(negedge sys_clk);
         check(pin_pullup_en, 1'b1);
         $display("test_port done");
      end
   endtask
   initial begin
      #400000;
      bad_count = bad_count + 1;
      complete_run;
   end
   initial begin
      repeat (6) @(negedge sys_clk);
      rst = 1'b0;
      check({state_r, ir_r}, {`ST_RESET, `IR_IDCODE});
      host.tlr;
      host.step(1'b0, 1'b0, q);
      test_ir;
      test_chain(4'h0);
      test_chain(4'h4);
      test_chain(4'h8);
      test_reset;
      test_port;
      complete_run;
   end
endmodule // test_jtag_tap_controller
